// ==== dcc_pkg.sv ====
// Constants, field layout and carrier types for the channel control fields
`default_nettype none
package dcc_pkg;
    localparam int unsigned NUM_CH        = 4;
    localparam int unsigned ADDR_W        = 8;
    // Register byte addresses
    localparam logic [7:0]  ADDR_CTL0     = 8'h00;
    localparam logic [7:0]  ADDR_CTL1     = 8'h04;
    localparam logic [7:0]  ADDR_CTL2     = 8'h08;
    localparam logic [7:0]  ADDR_CTL3     = 8'h0c;
    localparam logic [7:0]  ADDR_MODE     = 8'h10;
    // Field positions in channel_control
    localparam int unsigned SRC_ATTR_HI   = 31;
    localparam int unsigned SRC_ATTR_LO   = 29;
    localparam int unsigned SRC_WAIT_BIT  = 28;
    localparam int unsigned DST_ATTR_HI   = 27;
    localparam int unsigned DST_ATTR_LO   = 25;
    localparam int unsigned DST_WAIT_BIT  = 24;
    localparam int unsigned REQ_SMP_BIT   = 19;
    localparam int unsigned ACC_POL_BIT   = 18;
    localparam int unsigned ACK_CYC_BIT   = 17;
    localparam int unsigned ACK_POL_BIT   = 16;
    localparam int unsigned DST_STEP_HI   = 15;
    localparam int unsigned DST_STEP_LO   = 14;
    localparam int unsigned BURST_BIT     = 7;
    localparam int unsigned ONDEMAND_BIT  = 0;
    // Writable bits: full channels, and channels without bits 18 and 16
    localparam logic [31:0] CTL_WMASK_FULL   = 32'hff0f_fff7;
    localparam logic [31:0] CTL_WMASK_NARROW = 32'hff0a_fff7;
    localparam logic [31:0] CTL_RESET        = 32'h0000_0000;
    localparam logic [1:0]  STEP_FIXED    = 2'h0;
    localparam logic [1:0]  STEP_INC      = 2'h1;
    localparam logic [1:0]  STEP_DEC      = 2'h2;
    localparam logic [1:0]  STEP_BAD      = 2'h3;

    typedef enum logic [2:0] {
        SZ_1B  = 3'b000,
        SZ_2B  = 3'b001,
        SZ_4B  = 3'b010,
        SZ_8B  = 3'b011,
        SZ_32B = 3'b100
    } dcc_size_e;

    // One bus cycle of the transfer engine
    typedef struct packed {
        logic      valid;
        logic [1:0] ch;
        logic      accept;
        logic      is_write;
        logic      single_addr;
        logic      mem_to_dev;
        dcc_size_e size;
    } dcc_acc_s;

    // Card space selection for one access
    typedef struct packed {
        logic       valid;
        logic [2:0] space_attr;
        logic       area6;
    } dcc_pcm_s;
endpackage
`default_nettype wire

// ==== dcc_chan_ctl.sv ====
// Four channel control registers and the pin and address-step logic they steer
//
// Summary of operation
// R1 - Channels 2,3: bits 18,16 absent, read zero
// R2 - Reset clears every control register to zero
// R3 - Bits 31:29 give source card space
// R4 - Bits 27:25 give destination card space
// R5 - Bit 28 picks area-5/area-6 source waits
// R6 - Bit 24 picks area-5/area-6 destination waits
// R7 - Bits 23:20 reserved, read zero
// R8 - Bit 19: low level or falling edge
// R9 - Sampling select: channels 0,1, all on-demand
// R10 - With burst, bit 19 picks burst variant
// R11 - Bit 18 sets accept output polarity
// R12 - Bit 17 places ack in read/write cycle
// R13 - Ack cycle select validity per mode, variant
// R14 - Bit 16 sets ack output polarity
// R15 - Destination step ignored, single memory-to-device
// R16 - Channel 0 on-demand forces increment step
// R17 - Step fixed, up, down by size; 11 prohibited
//
// The implementer's own choices: the plain strobed port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module dcc_chan_ctl
    import dcc_pkg::*;
#(
    parameter bit LATER_VARIANT = 1'b0
) (
    // Clock and reset
    input  wire logic              I_CLK_SYS,
    input  wire logic              I_RST_N,
    // Register port
    input  wire logic [ADDR_W-1:0] I_ADDR,
    input  wire logic [31:0]       I_WDATA,
    input  wire logic              I_WR,
    input  wire logic              I_RD,
    output logic      [31:0]       O_RDATA,
    // Transfer engine
    input  wire dcc_acc_s          I_ACC,
    output logic [NUM_CH-1:0]      O_REQ_DETECT,
    output logic [NUM_CH-1:0]      O_BURST_EDGE,
    output logic [NUM_CH-1:0]      O_BURST_LEVEL,
    output dcc_pcm_s               O_PCM,
    output logic                   O_DST_STEP_VALID,
    output logic [6:0]             O_DST_STEP,
    output logic                   O_DST_STEP_BAD,
    // External device pins
    input  wire logic [NUM_CH-1:0] I_TRANSFER_REQUEST_IN_N,
    output logic [1:0]             O_REQUEST_ACCEPT_OUT,
    output logic [1:0]             O_TRANSFER_ACK_OUT,
    output logic                   O_ONDEMAND_ACK_OUT
);

    logic [31:0]       ctl      [NUM_CH];
    logic [31:0]       next_ctl [NUM_CH];
    logic              on_demand_transfer;
    logic              next_on_demand_transfer;
    logic [31:0]       rdata;
    logic [31:0]       next_rdata;

    // Register writes
    always_comb begin
        for (int c = 0; c < NUM_CH; c++) begin
            next_ctl[c] = ctl[c];
        end
        next_on_demand_transfer = on_demand_transfer;
        if (I_WR) begin
            case (I_ADDR)
                ADDR_CTL0: next_ctl[0] = I_WDATA & CTL_WMASK_FULL;   // [R7]
                ADDR_CTL1: next_ctl[1] = I_WDATA & CTL_WMASK_FULL;   // [R7]
                ADDR_CTL2: next_ctl[2] = I_WDATA & CTL_WMASK_NARROW; // [R1] [R7]
                ADDR_CTL3: next_ctl[3] = I_WDATA & CTL_WMASK_NARROW; // [R1] [R7]
                ADDR_MODE: next_on_demand_transfer = I_WDATA[ONDEMAND_BIT];
                default: ;
            endcase
        end
    end

    // Register reads, one cycle later; unmapped reads zero
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (I_RD) begin
            case (I_ADDR)
                ADDR_CTL0: next_rdata = ctl[0];
                ADDR_CTL1: next_rdata = ctl[1];
                ADDR_CTL2: next_rdata = ctl[2];
                ADDR_CTL3: next_rdata = ctl[3];
                ADDR_MODE: next_rdata = {31'h0000_0000, on_demand_transfer};
                default:   next_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RST_N) begin
            for (int c = 0; c < NUM_CH; c++) begin
                ctl[c] <= CTL_RESET; // [R2]
            end
            on_demand_transfer <= 1'b0;
            rdata              <= 32'h0000_0000;
        end else begin
            for (int c = 0; c < NUM_CH; c++) begin
                ctl[c] <= next_ctl[c];
            end
            on_demand_transfer <= next_on_demand_transfer;
            rdata              <= next_rdata;
        end
    end

    assign O_RDATA = rdata;

    // Request pin sampling, one instance per channel
    logic [NUM_CH-1:0] pin_prev;
    logic [NUM_CH-1:0] next_pin_prev;
    logic [NUM_CH-1:0] req_detect;
    logic [NUM_CH-1:0] next_req_detect;
    logic [NUM_CH-1:0] burst_edge;
    logic [NUM_CH-1:0] next_burst_edge;
    logic [NUM_CH-1:0] burst_level;
    logic [NUM_CH-1:0] next_burst_level;

    for (genvar g = 0; g < NUM_CH; g++) begin : g_req
        logic edge_mode;
        // Channels 2,3 fall back to level sampling in normal mode
        assign edge_mode = ctl[g][REQ_SMP_BIT] & ((g < 2) | on_demand_transfer); // [R9]
        always_comb begin
            next_pin_prev[g]    = I_TRANSFER_REQUEST_IN_N[g];
            next_req_detect[g]  = edge_mode ? (pin_prev[g] & ~I_TRANSFER_REQUEST_IN_N[g])
                                            : ~I_TRANSFER_REQUEST_IN_N[g]; // [R8]
            next_burst_edge[g]  = ctl[g][BURST_BIT] & edge_mode;  // [R10]
            next_burst_level[g] = ctl[g][BURST_BIT] & ~edge_mode; // [R10]
        end
    end

    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RST_N) begin
            pin_prev    <= '1;
            req_detect  <= '0;
            burst_edge  <= '0;
            burst_level <= '0;
        end else begin
            pin_prev    <= next_pin_prev;
            req_detect  <= next_req_detect;
            burst_edge  <= next_burst_edge;
            burst_level <= next_burst_level;
        end
    end

    assign O_REQ_DETECT  = req_detect;
    assign O_BURST_EDGE  = burst_edge;
    assign O_BURST_LEVEL = burst_level;

    // Accept and acknowledge pins
    logic [1:0]  accept_out;
    logic [1:0]  next_accept_out;
    logic [1:0]  ack_out;
    logic [1:0]  next_ack_out;
    logic        od_ack;
    logic        next_od_ack;
    logic [31:0] cur;
    logic        am_valid_od;

    assign cur = ctl[I_ACC.ch];
    // On-demand ack cycle select: channels 1-3, or all on the later variant
    assign am_valid_od = (I_ACC.ch != 2'd0) | LATER_VARIANT; // [R13]

    always_comb begin
        logic hit;
        logic ack_now;
        hit = 1'b0;
        ack_now = 1'b0;
        next_od_ack = 1'b0;
        for (int c = 0; c < 2; c++) begin
            hit = I_ACC.valid & (I_ACC.ch == c[1:0]) & ~on_demand_transfer;
            // Polarity bits only count in normal mode
            next_accept_out[c] = (hit & I_ACC.accept)
                ^ (ctl[c][ACC_POL_BIT] & ~on_demand_transfer); // [R11]
            ack_now = hit & (I_ACC.single_addr | (I_ACC.is_write == ctl[c][ACK_CYC_BIT])); // [R12] [R13]
            next_ack_out[c] = ack_now ^ (ctl[c][ACK_POL_BIT] & ~on_demand_transfer); // [R14]
        end
        if (I_ACC.valid & on_demand_transfer) begin
            // Active-high in on-demand mode
            next_od_ack = I_ACC.single_addr
                | (I_ACC.is_write == (cur[ACK_CYC_BIT] & am_valid_od)); // [R12] [R13]
        end
    end

    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RST_N) begin
            accept_out <= 2'b00;
            ack_out    <= 2'b00;
            od_ack     <= 1'b0;
        end else begin
            accept_out <= next_accept_out;
            ack_out    <= next_ack_out;
            od_ack     <= next_od_ack;
        end
    end

    assign O_REQUEST_ACCEPT_OUT = accept_out;
    assign O_TRANSFER_ACK_OUT   = ack_out;
    assign O_ONDEMAND_ACK_OUT   = od_ack;

    // Card space and destination step per access
    dcc_pcm_s   pcm;
    dcc_pcm_s   next_pcm;
    logic       step_valid;
    logic       next_step_valid;
    logic [6:0] step;
    logic [6:0] next_step;
    logic       step_bad;
    logic       next_step_bad;

    always_comb begin
        logic [1:0] mode;
        logic [6:0] mag;
        mode = cur[DST_STEP_HI:DST_STEP_LO];
        mag  = 7'd0;
        next_pcm.valid = I_ACC.valid;
        if (I_ACC.is_write) begin
            next_pcm.space_attr = cur[DST_ATTR_HI:DST_ATTR_LO]; // [R4]
            next_pcm.area6      = cur[DST_WAIT_BIT];            // [R6]
        end else begin
            next_pcm.space_attr = cur[SRC_ATTR_HI:SRC_ATTR_LO]; // [R3]
            next_pcm.area6      = cur[SRC_WAIT_BIT];            // [R5]
        end
        if (on_demand_transfer && I_ACC.ch == 2'd0) begin
            mode = STEP_INC; // [R16]
        end
        case (I_ACC.size)
            SZ_1B:   mag = 7'd1;
            SZ_2B:   mag = 7'd2;
            SZ_4B:   mag = 7'd4;
            SZ_8B:   mag = 7'd8;
            SZ_32B:  mag = 7'd32;
            default: mag = 7'd0;
        endcase
        next_step_valid = I_ACC.valid & (I_ACC.is_write | I_ACC.single_addr)
                        & ~(I_ACC.single_addr & I_ACC.mem_to_dev); // [R15]
        next_step_bad   = next_step_valid & (mode == STEP_BAD);   // [R17]
        case (mode)
            STEP_INC: next_step = mag;                            // [R17]
            STEP_DEC: next_step = 7'(-mag);                       // [R17]
            default:  next_step = 7'd0;
        endcase
        if (!next_step_valid) begin
            next_step = 7'd0;
        end
    end

    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RST_N) begin
            pcm        <= '0;
            step_valid <= 1'b0;
            step       <= 7'd0;
            step_bad   <= 1'b0;
        end else begin
            pcm        <= next_pcm;
            step_valid <= next_step_valid;
            step       <= next_step;
            step_bad   <= next_step_bad;
        end
    end

    assign O_PCM            = pcm;
    assign O_DST_STEP_VALID = step_valid;
    assign O_DST_STEP       = step;
    assign O_DST_STEP_BAD   = step_bad;

endmodule
`default_nettype wire

// ==== dcc_chan_ctl_props.sv ====
// Port assertions for the channel control block
`timescale 1ns/100ps
`default_nettype none
module dcc_chan_ctl_props
    import dcc_pkg::*;
(
    // Clock, reset and register port
    input wire logic        I_CLK_SYS,
    input wire logic        I_RST_N,
    input wire logic [7:0]  I_ADDR,
    input wire logic [31:0] I_WDATA,
    input wire logic        I_WR,
    input wire logic        I_RD,
    input wire logic [31:0] O_RDATA,
    // Engine and pins
    input wire dcc_acc_s    I_ACC,
    input wire logic [3:0]  O_REQ_DETECT,
    input wire logic        O_DST_STEP_VALID,
    input wire logic [6:0]  O_DST_STEP,
    input wire logic [3:0]  I_TRANSFER_REQUEST_IN_N,
    input wire logic [1:0]  O_REQUEST_ACCEPT_OUT,
    input wire logic [1:0]  O_TRANSFER_ACK_OUT
);
    // Shadow of channel 0 bits 18:14 and the mode bit
    logic [4:0] sh;
    logic       md;
    always_ff @(posedge I_CLK_SYS)
        if (!I_RST_N) {sh, md} <= 6'h00;
        else if (I_WR && I_ADDR == ADDR_CTL0) sh <= I_WDATA[18:14];
        else if (I_WR && I_ADDR == ADDR_MODE) md <= I_WDATA[0];
    default clocking dc @(posedge I_CLK_SYS); endclocking
    default disable iff (!I_RST_N);
    AST_RESET_CLEAR: assert property ($rose(I_RST_N) |-> O_RDATA == 32'h0 && O_REQ_DETECT == 4'h0)
        else $error("outputs not clear after reset");
    AST_NARROW_ZERO: assert property ($past(I_RD && I_ADDR[3]) |-> {O_RDATA[18], O_RDATA[16]} == 2'h0)
        else $error("absent bits read nonzero");
    AST_REQ_HIGH: assert property ((O_REQ_DETECT & $past(I_TRANSFER_REQUEST_IN_N)) == 4'h0)
        else $error("request seen while pin high");
    AST_REQ_FALL: assert property ((~O_REQ_DETECT & ~$past(I_TRANSFER_REQUEST_IN_N) &
        $past(I_TRANSFER_REQUEST_IN_N, 2)) == 4'h0) else $error("falling request missed");
    AST_ACCEPT_POL: assert property (!$past(md) |-> O_REQUEST_ACCEPT_OUT[0] ==
        $past((I_ACC.valid && I_ACC.ch == 2'h0 && I_ACC.accept) ^ sh[4])) else $error("accept pin wrong");
    AST_ACK_CYCLE: assert property (!$past(md) |-> O_TRANSFER_ACK_OUT[0] == $past((I_ACC.valid &&
        I_ACC.ch == 2'h0 && (I_ACC.single_addr || I_ACC.is_write == sh[3])) ^ sh[2]))
        else $error("ack pin wrong");
    AST_STEP_SINGLE: assert property ($past(I_ACC.valid && I_ACC.single_addr && I_ACC.mem_to_dev)
        |-> !O_DST_STEP_VALID) else $error("step on memory to device");
    AST_STEP_CH0: assert property ($past(md && I_ACC.valid && I_ACC.ch == 2'h0 && I_ACC.is_write &&
        !I_ACC.single_addr && I_ACC.size == SZ_4B) |-> O_DST_STEP_VALID && O_DST_STEP == 7'h04)
        else $error("channel 0 step not forced up");
endmodule
bind dcc_chan_ctl dcc_chan_ctl_props u_props (.*);
`default_nettype wire

// ==== dcc_ext_dev.sv ====
// External device model driving the active-low request pins
`timescale 1ns/100ps
`default_nettype none
module dcc_ext_dev (
    // Requests wanted by the bench
    input  wire logic [3:0] i_want,
    // Request pins towards the block
    output wire logic [3:0] o_req_n
);
    assign o_req_n = ~i_want;
endmodule
`default_nettype wire

// ==== dcc_chan_ctl_tb.sv ====
// Directed bench for the channel control block
`timescale 1ns/100ps
`default_nettype none
module dcc_chan_ctl_tb
    import dcc_pkg::*;
;
    logic        I_CLK_SYS, I_RST_N, I_WR, I_RD, O_DST_STEP_VALID, O_DST_STEP_BAD, O_ONDEMAND_ACK_OUT;
    logic [7:0]  I_ADDR;
    logic [31:0] I_WDATA, O_RDATA;
    logic [3:0]  O_REQ_DETECT, O_BURST_EDGE, O_BURST_LEVEL, I_TRANSFER_REQUEST_IN_N, want;
    logic [1:0]  O_REQUEST_ACCEPT_OUT, O_TRANSFER_ACK_OUT;
    logic [6:0]  O_DST_STEP;
    logic [7:0]  steps [4] = '{8'h00, 8'h20, 8'h60, 8'h80};
    dcc_acc_s    I_ACC;
    dcc_pcm_s    O_PCM;
    int          num_errors, total_checks, n;

    dcc_chan_ctl u_dcc_chan_ctl (.*);
    dcc_ext_dev  u_dcc_ext_dev (.i_want(want), .o_req_n(I_TRANSFER_REQUEST_IN_N));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
        @(posedge I_CLK_SYS);
        I_WR <= w;
        I_RD <= !w;
        I_ADDR <= a;
        I_WDATA <= v;
        @(posedge I_CLK_SYS);
        I_WR <= 1'b0;
        I_RD <= 1'b0;
        @(negedge I_CLK_SYS);
    endtask
    // One engine cycle: {is_write, single_addr, mem_to_dev}
    task automatic acc(input logic [1:0] c, input logic [2:0] wsm, input dcc_size_e z);
        @(posedge I_CLK_SYS);
        I_ACC <= {1'b1, c, 1'b1, wsm, z};
        @(posedge I_CLK_SYS);
        I_ACC <= '0;
        @(negedge I_CLK_SYS);
    endtask
    // Three-cycle low pulse, counting detect cycles
    task automatic req(input int c, input logic [31:0] exp);
        n = 0;
        for (int i = 0; i < 8; i++) begin
            @(posedge I_CLK_SYS);
            want[c] <= (i < 3);
            @(negedge I_CLK_SYS);
            n += int'(O_REQ_DETECT[c]);
        end
        chk(n, exp);
    endtask
    task automatic summarize();
        $display("Checks %0d, mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        I_CLK_SYS = 1'b0;
        forever #25 I_CLK_SYS = ~I_CLK_SYS;
    end
    initial begin
        repeat (4000) @(posedge I_CLK_SYS);
        num_errors++;
        summarize();
    end
    initial begin
        {I_RST_N, I_WR, I_RD, I_ADDR, I_WDATA, I_ACC, want} = '0;
        repeat (8) @(posedge I_CLK_SYS);
        I_RST_N <= 1'b1;
        for (int c = 0; c < 4; c++) begin
            bus(1'b0, 8'(4 * c), 32'h0);
            chk(O_RDATA, CTL_RESET);
            bus(1'b1, 8'(4 * c), 32'hffff_ffff);
            bus(1'b0, 8'(4 * c), 32'h0);
            chk(O_RDATA, c < 2 ? 32'hff0f_fff7 : 32'hff0a_fff7);
        end
        bus(1'b0, 8'h20, 32'h0);
        chk(O_RDATA, 32'h0);
        for (int a = 0; a < 8; a++) begin
            bus(1'b1, ADDR_CTL0, {3'(a), a[0], 3'(7 - a), ~a[0], 24'h0});
            acc(2'h0, 3'h0, SZ_4B);
            chk(32'(O_PCM), {27'h0, 1'b1, 3'(a), a[0]});
            acc(2'h0, 3'h4, SZ_4B);
            chk(32'(O_PCM), {27'h0, 1'b1, 3'(7 - a), ~a[0]});
        end
        $display("Register test done");
        bus(1'b1, ADDR_CTL0, 32'h0008_0000);
        bus(1'b1, ADDR_CTL2, 32'h0008_0080);
        req(0, 1);
        req(2, 3);
        chk({O_BURST_EDGE, O_BURST_LEVEL}, 8'h2c);
        bus(1'b1, ADDR_MODE, 32'h1);
        req(2, 1);
        chk({O_BURST_EDGE, O_BURST_LEVEL}, 8'he0);
        $display("Request test done");
        bus(1'b1, ADDR_MODE, 32'h0);
        bus(1'b1, ADDR_CTL0, 32'h0005_0000);
        acc(2'h1, 3'h0, SZ_4B);
        chk({O_REQUEST_ACCEPT_OUT, O_TRANSFER_ACK_OUT}, 4'h7);
        acc(2'h0, 3'h0, SZ_4B);
        chk({O_REQUEST_ACCEPT_OUT, O_TRANSFER_ACK_OUT}, 4'ha);
        acc(2'h0, 3'h4, SZ_4B);
        chk({O_REQUEST_ACCEPT_OUT, O_TRANSFER_ACK_OUT}, 4'hb);
        acc(2'h0, 3'h6, SZ_4B);
        chk({O_REQUEST_ACCEPT_OUT, O_TRANSFER_ACK_OUT}, 4'ha);
        bus(1'b1, ADDR_MODE, 32'h1);
        acc(2'h1, 3'h4, SZ_4B);
        chk(O_ONDEMAND_ACK_OUT, 1);
        acc(2'h1, 3'h0, SZ_4B);
        chk(O_ONDEMAND_ACK_OUT, 0);
        bus(1'b1, ADDR_CTL0, 32'h0007_0000);
        acc(2'h0, 3'h0, SZ_4B);
        chk({O_REQUEST_ACCEPT_OUT, O_TRANSFER_ACK_OUT, O_ONDEMAND_ACK_OUT}, 5'h01);
        bus(1'b1, ADDR_CTL0, 32'h0000_8000);
        acc(2'h0, 3'h4, SZ_4B);
        chk({O_DST_STEP_VALID, O_DST_STEP}, 8'h84);
        $display("Pin test done");
        bus(1'b1, ADDR_MODE, 32'h0);
        for (int m = 0; m < 4; m++) begin
            bus(1'b1, ADDR_CTL0, 32'(m) << 14);
            acc(2'h0, 3'h4, SZ_32B);
            chk({O_DST_STEP_BAD, O_DST_STEP}, steps[m]);
        end
        acc(2'h0, 3'h3, SZ_32B);
        chk(O_DST_STEP_VALID, 0);
        $display("Step test done");
        // Mid-run reset clears the loaded control registers
        @(posedge I_CLK_SYS);
        I_RST_N <= 1'b0;
        repeat (2) @(posedge I_CLK_SYS);
        I_RST_N <= 1'b1;
        bus(1'b0, ADDR_CTL1, 32'h0);
        chk(O_RDATA, CTL_RESET);
        bus(1'b0, ADDR_CTL0, 32'h0);
        chk(O_RDATA, CTL_RESET);
        $display("Reset test done");
        summarize();
    end
endmodule
`default_nettype wire
